// File: pkg/irq_gate_pkg.sv
/*
 * irq_gate_pkg: register map, field positions and reset values for the
 * host interrupt enable gating block.
 * assumes: a 32-bit avalon-mm slave port, one register per aligned word.
 */
package irq_gate_pkg;
	localparam int          addr_width       = 4;
	localparam int          data_width       = 32;
	// register byte offsets
	localparam logic [3:0]  enable_ctrl_off  = 4'h0;
	localparam logic [3:0]  serial_irq_control_1_off = 4'h4;
	localparam logic [3:0]  mode_ctrl_off    = 4'h8;
	localparam logic [3:0]  status_off       = 4'hc;
	// enable_ctrl field positions
	localparam int          ch1_irq1_bit     = 0;
	localparam int          ch1_irq12_bit    = 1;
	localparam int          ch2_smi_bit      = 2;
	// serial_irq_control_1 field positions
	localparam int          ch3_irq11_bit    = 7;
	// mode_ctrl field positions
	localparam int          direct_mode_bit  = 0;
	// status field positions: flags then requests
	localparam int          st_flag1_bit     = 0;
	localparam int          st_flag2_bit     = 1;
	localparam int          st_flag3a_bit    = 2;
	localparam int          st_req_irq1_bit  = 4;
	localparam int          st_req_irq12_bit = 5;
	localparam int          st_req_smi_bit   = 6;
	localparam int          st_req_irq11_bit = 7;
	// enable index inside the packed enable vector
	localparam int          num_enables      = 4;
	localparam int          en_irq1          = 0;
	localparam int          en_irq12         = 1;
	localparam int          en_smi           = 2;
	localparam int          en_irq11         = 3;
	localparam logic [3:0]  enables_reset    = 4'h0;
	localparam logic [31:0] unmapped_read    = 32'h0000_0000;
	// answer latency of the slave in clock cycles
	localparam int          bus_wait_cycles  = 1;
endpackage : irq_gate_pkg

// File: core/irq_gate.sv
/*
 * irq_gate: per-source host interrupt enables (smi, irq1, irq12, irq11)
 * gated by output-full flags of host channels 1, 2 and 3a, plus direct mode.
 * assumes: flags, data-register write strobes and local resets come from
 * logic on sys_clk; the lpc reset requests arrive from outside and are
 * synchronised here; registers are reached by a local avalon-mm master.
 */
// The register offsets and the Avalon-MM register port are this design's own decisions.
// Contract
// - ch2 smi requested on flag set, enabled
// - direct mode: ch2 smi follows enable only
// - ch2 smi enable clears on 0, reset, flag-clear outside direct mode
// - enable sets only by write 1 after read 0
// - ch1 irq12 requested on flag set, enabled
// - ch1 irq12 enable clears on 0, reset, flag-clear
// - ch1 irq1 requested on flag set, enabled
// - ch1 irq1 enable clears on 0, reset, flag-clear
// - ch3 irq11 requested on flag set, enabled
// - direct mode: ch3 irq11 follows enable only
// - ch3 irq11 enable clears on 0, reset, flag-clear outside direct mode
// - direct mode bit selects gating
module irq_gate
	import irq_gate_pkg::*;
(
	// clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rst_n,
	// lpc reset requests, asynchronous to sys_clk
	input  wire logic                               lpc_hw_reset_n,
	input  wire logic                               lpc_sw_reset,
	// channel flags and output data register write strobes
	input  wire logic                               ch1_out_full_flag,
	input  wire logic                               ch2_out_full_flag,
	input  wire logic                               ch3a_out_full_flag,
	input  wire logic                               ch1_out_data_reg_wr,
	input  wire logic                               ch2_out_data_reg_wr,
	input  wire logic                               ch3_out_data_reg_wr,
	// avalon-mm slave
	input  wire logic [irq_gate_pkg::addr_width-1:0] avs_address,
	input  wire logic                               avs_read,
	input  wire logic                               avs_write,
	input  wire logic [irq_gate_pkg::data_width-1:0] avs_writedata,
	input  wire logic [3:0]                         avs_byteenable,
	output logic      [irq_gate_pkg::data_width-1:0] avs_readdata,
	output logic                                    avs_waitrequest,
	// host interrupt requests toward the serial irq framer
	output logic                                    host_irq1_req,
	output logic                                    host_irq12_req,
	output logic                                    host_smi_req,
	output logic                                    host_irq11_req
);
	import irq_gate_pkg::*;

	typedef struct packed {
		logic [1:0]            hw_sync;
		logic [1:0]            sw_sync;
		logic [2:0]            flag_prev;
		logic [num_enables-1:0] enable;
		logic [num_enables-1:0] armed;
		logic                  direct_enable_mode;
		logic [3:0]            req;
		logic                  ack;
		logic [data_width-1:0] rdata;
	} state_type;

	state_type s_q;
	state_type s_d;

	logic       lpc_reset;
	logic [2:0] flag_now;
	logic [2:0] flag_fall;
	logic [2:0] flag_rise_wr;
	logic       bus_req;
	logic       bus_take;
	logic [31:0] rd_word;
	logic [num_enables-1:0] wr_hit;
	logic [num_enables-1:0] wr_val;
	logic [num_enables-1:0] rd_hit;
	logic [num_enables-1:0] flag_clr;

	always_comb begin
		s_d = s_q;
		lpc_reset = 1'b0;
		flag_now = '0;
		flag_fall = '0;
		flag_rise_wr = '0;
		bus_req = 1'b0;
		bus_take = 1'b0;
		rd_word = unmapped_read;
		wr_hit = '0;
		wr_val = '0;
		rd_hit = '0;
		flag_clr = '0;

		// only the second stage feeds logic
		s_d.hw_sync = {s_q.hw_sync[0], ~lpc_hw_reset_n};
		s_d.sw_sync = {s_q.sw_sync[0], lpc_sw_reset};
		lpc_reset = s_q.hw_sync[1] | s_q.sw_sync[1];

		flag_now = {ch3a_out_full_flag, ch2_out_full_flag, ch1_out_full_flag};
		flag_fall = s_q.flag_prev & ~flag_now;
		// a flag set by a write to its data register
		flag_rise_wr[0] = ch1_out_full_flag & ~s_q.flag_prev[0] & ch1_out_data_reg_wr;
		flag_rise_wr[1] = ch2_out_full_flag & ~s_q.flag_prev[1] & ch2_out_data_reg_wr;
		flag_rise_wr[2] = ch3a_out_full_flag & ~s_q.flag_prev[2] & ch3_out_data_reg_wr;
		s_d.flag_prev = flag_now;

		// one wait cycle, answer on the second edge
		bus_req = avs_read | avs_write;
		bus_take = bus_req & s_q.ack;
		s_d.ack = bus_req & ~s_q.ack;

		case (avs_address)
			enable_ctrl_off: begin
				rd_word[ch1_irq1_bit] = s_q.enable[en_irq1];
				rd_word[ch1_irq12_bit] = s_q.enable[en_irq12];
				rd_word[ch2_smi_bit] = s_q.enable[en_smi];
			end
			serial_irq_control_1_off: begin
				rd_word[ch3_irq11_bit] = s_q.enable[en_irq11];
			end
			mode_ctrl_off: begin
				rd_word[direct_mode_bit] = s_q.direct_enable_mode;
			end
			status_off: begin
				rd_word[st_flag1_bit] = s_q.flag_prev[0];
				rd_word[st_flag2_bit] = s_q.flag_prev[1];
				rd_word[st_flag3a_bit] = s_q.flag_prev[2];
				rd_word[st_req_irq1_bit] = s_q.req[en_irq1];
				rd_word[st_req_irq12_bit] = s_q.req[en_irq12];
				rd_word[st_req_smi_bit] = s_q.req[en_smi];
				rd_word[st_req_irq11_bit] = s_q.req[en_irq11];
			end
			default: begin
				rd_word = unmapped_read;
			end
		endcase
		// load read data as ack rises, so it stands at the taking edge
		if (bus_req && avs_read && !s_q.ack) begin
			s_d.rdata = rd_word;
		end

		// bus hits per enable; fields all sit in byte lane 0
		if (bus_take && avs_byteenable[0]) begin
			if (avs_address == enable_ctrl_off) begin
				wr_hit[en_irq1] = avs_write;
				wr_hit[en_irq12] = avs_write;
				wr_hit[en_smi] = avs_write;
				rd_hit[en_irq1] = avs_read;
				rd_hit[en_irq12] = avs_read;
				rd_hit[en_smi] = avs_read;
			end
			if (avs_address == serial_irq_control_1_off) begin
				wr_hit[en_irq11] = avs_write;
				rd_hit[en_irq11] = avs_read;
			end
			if (avs_write && avs_address == mode_ctrl_off) begin
				s_d.direct_enable_mode = avs_writedata[direct_mode_bit];
			end
		end
		wr_val[en_irq1] = avs_writedata[ch1_irq1_bit];
		wr_val[en_irq12] = avs_writedata[ch1_irq12_bit];
		wr_val[en_smi] = avs_writedata[ch2_smi_bit];
		wr_val[en_irq11] = avs_writedata[ch3_irq11_bit];

		// ch1 clears always; ch2/ch3 only outside direct mode
		flag_clr[en_irq1] = flag_fall[0];
		flag_clr[en_irq12] = flag_fall[0];
		flag_clr[en_smi] = flag_fall[1] & ~s_q.direct_enable_mode;
		flag_clr[en_irq11] = flag_fall[2] & ~s_q.direct_enable_mode;

		for (int i = 0; i < num_enables; i++) begin
			// a read of 0 arms the bit; a write to its register consumes the arming
			if (rd_hit[i] && !s_q.enable[i]) begin
				s_d.armed[i] = 1'b1;
			end
			if (wr_hit[i]) begin
				s_d.armed[i] = 1'b0;
				if (!wr_val[i]) begin
					s_d.enable[i] = 1'b0;
				end else if (s_q.armed[i]) begin
					s_d.enable[i] = 1'b1;
				end
			end
			if (flag_clr[i]) begin
				s_d.enable[i] = 1'b0;
				s_d.armed[i] = 1'b0;
			end
			if (lpc_reset) begin
				s_d.enable[i] = 1'b0;
				s_d.armed[i] = 1'b0;
			end
		end

		// request is a level held until the enable drops or the flag drops; in direct mode smi/irq11 ignore the flag
		s_d.req[en_irq1] = s_q.enable[en_irq1] & (s_q.req[en_irq1] | flag_rise_wr[0])
			& ch1_out_full_flag;
		s_d.req[en_irq12] = s_q.enable[en_irq12] & (s_q.req[en_irq12] | flag_rise_wr[0])
			& ch1_out_full_flag;
		if (s_q.direct_enable_mode) begin
			s_d.req[en_smi] = s_q.enable[en_smi];
			s_d.req[en_irq11] = s_q.enable[en_irq11];
		end else begin
			s_d.req[en_smi] = s_q.enable[en_smi] & (s_q.req[en_smi] | flag_rise_wr[1])
				& ch2_out_full_flag;
			s_d.req[en_irq11] = s_q.enable[en_irq11] & (s_q.req[en_irq11] | flag_rise_wr[2])
				& ch3a_out_full_flag;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_q.hw_sync <= '0;
			s_q.sw_sync <= '0;
			s_q.flag_prev <= '0;
			s_q.enable <= enables_reset;
			s_q.armed <= '0;
			s_q.direct_enable_mode <= 1'b0;
			s_q.req <= '0;
			s_q.ack <= 1'b0;
			s_q.rdata <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = ~s_q.ack;
	assign host_irq1_req = s_q.req[en_irq1];
	assign host_irq12_req = s_q.req[en_irq12];
	assign host_smi_req = s_q.req[en_smi];
	assign host_irq11_req = s_q.req[en_irq11];
endmodule : irq_gate

// File: verification/irq_gate_sva.sv
/* irq_gate_sva: port checks of irq_gate.
   assumes: bound into irq_gate, one sys_clk domain. */
module irq_gate_sva (
	// clock, resets
	input wire logic sys_clk, rst_n, lpc_hw_reset_n, lpc_sw_reset,
	// channel 1 events
	input wire logic ch1_out_full_flag, ch1_out_data_reg_wr,
	// bus
	input wire logic avs_read, avs_write, avs_waitrequest,
	// requests
	input wire logic host_irq1_req, host_irq12_req, host_smi_req, host_irq11_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_irq1_flag; !ch1_out_full_flag [*3] |-> !host_irq1_req; endproperty
	property p_irq12_flag; !ch1_out_full_flag [*3] |-> !host_irq12_req; endproperty
	property p_irq1_cause; $rose(host_irq1_req) |-> $past(ch1_out_data_reg_wr); endproperty
	property p_irq12_cause; $rose(host_irq12_req) |-> $past(ch1_out_data_reg_wr); endproperty
	// lpc reset passes a 2-ff sync before it clears
	property p_hw_smi; !lpc_hw_reset_n [*6] |-> !host_smi_req; endproperty
	property p_sw_irq11; lpc_sw_reset [*6] |-> !host_irq11_req; endproperty
	property p_rst;
		@(posedge sys_clk) disable iff (1'b0) !rst_n |=> !host_irq1_req && !host_smi_req && avs_waitrequest;
	endproperty
	property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_irq1_flag: assert property (p_irq1_flag) else $error("irq1 request without flag");
	a_irq12_flag: assert property (p_irq12_flag) else $error("irq12 request without flag");
	a_irq1_cause: assert property (p_irq1_cause) else $error("irq1 rose without write");
	a_irq12_cause: assert property (p_irq12_cause) else $error("irq12 rose without write");
	a_hw_smi: assert property (p_hw_smi) else $error("smi request in lpc reset");
	a_sw_irq11: assert property (p_sw_irq11) else $error("irq11 request in lpc reset");
	a_rst: assert property (p_rst) else $error("outputs not idle in reset");
	a_wait: assert property (p_wait) else $error("waitrequest not dropped");
	c_irq1: cover property ($rose(host_irq1_req));
	c_smi: cover property ($rose(host_smi_req));
	c_irq11: cover property ($rose(host_irq11_req));
endmodule : irq_gate_sva

bind irq_gate irq_gate_sva chk_u (.sys_clk, .rst_n, .lpc_hw_reset_n, .lpc_sw_reset, .ch1_out_full_flag,
	.ch1_out_data_reg_wr, .avs_read, .avs_write, .avs_waitrequest, .host_irq1_req, .host_irq12_req,
	.host_smi_req, .host_irq11_req);

// File: verification/lpc_host_model.sv
/* lpc_host_model: host side, source of lpc resets on its own clock.
   assumes: go inputs held far longer than one lpc clock. */
module lpc_host_model (
	input  wire logic hw_go,
	input  wire logic sw_go,
	output logic      lpc_hw_reset_n,
	output logic      lpc_sw_reset
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lpc_clk = 1'b0;
	initial lpc_hw_reset_n = 1'b1;
	initial lpc_sw_reset = 1'b0;
	initial forever #62.5 lpc_clk = ~lpc_clk;
	// host only resets; it has no register path into the block
	always @(posedge lpc_clk) begin
		lpc_hw_reset_n <= !hw_go;
		lpc_sw_reset <= sw_go;
	end
endmodule : lpc_host_model

// File: verification/tb.sv
/* tb: register and request tests of irq_gate.
   assumes: irq_gate_pkg map, two-cycle bus access. */
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import irq_gate_pkg::*;
	logic sys_clk = 0, rst_n = 0, rd = 0, wt = 0, hw_go = 0, sw_go = 0;
	logic [2:0] flag = 0, wr = 0;
	logic [3:0] adr = 0;
	logic [31:0] wdat = 0, q;
	wire [31:0] rdat;
	wire [3:0] req;
	wire wreq, lpc_hw_reset_n, lpc_sw_reset;
	int err_count = 0, num_checks = 0;
	irq_gate dut_u (.sys_clk, .rst_n, .lpc_hw_reset_n, .lpc_sw_reset, .ch1_out_full_flag(flag[0]),
		.ch2_out_full_flag(flag[1]), .ch3a_out_full_flag(flag[2]), .ch1_out_data_reg_wr(wr[0]),
		.ch2_out_data_reg_wr(wr[1]), .ch3_out_data_reg_wr(wr[2]), .avs_address(adr), .avs_read(rd),
		.avs_write(wt), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .host_irq1_req(req[0]), .host_irq12_req(req[1]),
		.host_smi_req(req[2]), .host_irq11_req(req[3]));
	lpc_host_model host_u (.hw_go, .sw_go, .lpc_hw_reset_n, .lpc_sw_reset);
	initial forever #4 sys_clk = ~sys_clk;
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task chk(string n, logic [31:0] e, logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task bus(logic w, logic [3:0] a, logic [31:0] d);
		int i;
		i = 0;
		adr <= a;
		wdat <= d;
		rd <= !w;
		wt <= w;
		do begin
			@(posedge sys_clk);
			i++;
		end while (wreq !== 1'b0 && i < 20);
		if (wreq !== 1'b0) begin
			err_count++;
			report_and_stop;
		end
		// readdata stands at the taking edge
		q = rdat;
		rd <= 1'b0;
		wt <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task rchk(string n, logic [3:0] a, logic [31:0] e);
		bus(0, a, 0);
		chk(n, e, q);
	endtask : rchk
	// a read of 0 arms the write of 1
	task aw(logic [3:0] a, logic [31:0] d);
		bus(0, a, 0);
		bus(1, a, d);
	endtask : aw
	task push(int c);
		flag[c] <= 1'b1;
		wr[c] <= 1'b1;
		@(posedge sys_clk);
		wr[c] <= 1'b0;
	endtask : push
	task lpc(logic hw);
		hw_go <= hw;
		sw_go <= !hw;
		cyc(40);
		hw_go <= 1'b0;
		sw_go <= 1'b0;
		cyc(40);
	endtask : lpc
	initial begin
		cyc(3);
		rst_n <= 1'b1;
		cyc(1);
		rchk("enable_ctrl", enable_ctrl_off, 0);
		rchk("serial_irq_control_1", serial_irq_control_1_off, 0);
		rchk("mode_ctrl", mode_ctrl_off, 0);
		rchk("unmapped", 4'h3, unmapped_read);
		bus(1, enable_ctrl_off, 0);
		bus(1, enable_ctrl_off, 32'h7);
		rchk("enable_ctrl", enable_ctrl_off, 0);
		bus(1, enable_ctrl_off, 32'h7);
		rchk("enable_ctrl", enable_ctrl_off, 32'h7);
		push(0);
		push(1);
		cyc(2);
		chk("req", 4'h7, req);
		flag[1:0] <= 2'h0;
		cyc(3);
		chk("req", 0, req);
		rchk("enable_ctrl", enable_ctrl_off, 0);
		push(0);
		cyc(2);
		chk("req", 0, req);
		flag[0] <= 1'b0;
		aw(enable_ctrl_off, 32'h1);
		bus(1, enable_ctrl_off, 0);
		rchk("enable_ctrl", enable_ctrl_off, 0);
		aw(mode_ctrl_off, 32'h1);
		aw(serial_irq_control_1_off, 32'h80);
		aw(enable_ctrl_off, 32'h4);
		cyc(2);
		chk("req", 4'hc, req);
		flag[2] <= 1'b1;
		cyc(1);
		flag[2] <= 1'b0;
		cyc(2);
		rchk("serial_irq_control_1", serial_irq_control_1_off, 32'h80);
		lpc(1'b1);
		chk("req", 0, req);
		rchk("serial_irq_control_1", serial_irq_control_1_off, 0);
		bus(1, mode_ctrl_off, 0);
		aw(serial_irq_control_1_off, 32'h80);
		cyc(2);
		chk("req", 0, req);
		push(2);
		cyc(2);
		chk("req", 4'h8, req);
		flag[2] <= 1'b0;
		cyc(3);
		rchk("serial_irq_control_1", serial_irq_control_1_off, 0);
		aw(enable_ctrl_off, 32'h2);
		lpc(1'b0);
		rchk("enable_ctrl", enable_ctrl_off, 0);
		report_and_stop;
	end
endmodule : tb
